/* src/timer_pkg.sv */
// Shared constants, types and register map of the dual timer unit
package timer_pkg;
  localparam logic [7:0] OFF_CORE_CTRL = 8'h00;
  localparam logic [7:0] OFF_AUX_CTRL = 8'h04;
  localparam logic [7:0] OFF_CORE_CNT = 8'h08;
  localparam logic [7:0] OFF_AUX_CNT = 8'h0c;
  localparam logic [7:0] OFF_CAPTURE_RELOAD = 8'h10;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h14;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h18;
  localparam int CORE_IDX = 0;
  localparam int AUX_IDX = 1;
  localparam int NTMR = 2;
  localparam int PRE_W = 8;
  localparam logic [PRE_W-1:0] PRE_RST = 8'h00;
  localparam int IRQ_CORE_WRAP = 0;
  localparam int IRQ_AUX_WRAP = 1;
  localparam int IRQ_CAPTURE = 2;
  localparam int NIRQ = 3;
  localparam logic [NIRQ-1:0] IRQ_RST = 3'h0;
  localparam int PIN_CNT0 = 0;
  localparam int PIN_DIR0 = 2;
  localparam int PIN_CAPTURE = 4;
  localparam int PIN_NB_CNT = 5;
  localparam int PIN_NB_DIR = 6;
  localparam int NPIN = 7;
  localparam logic [NPIN-1:0] PIN_RST = 7'h00;
  typedef enum logic [1:0] {
    SRC_PRESC = 2'b00,
    SRC_PIN = 2'b01,
    SRC_LATCH = 2'b10,
    SRC_OFF = 2'b11
  } clk_src_e;
  typedef enum logic [1:0] {
    CAP_PIN = 2'b00,
    CAP_NB_CNT = 2'b01,
    CAP_NB_DIR = 2'b10,
    CAP_NB_BOTH = 2'b11
  } cap_src_e;
  typedef struct packed {
    logic out_en;
    logic clr_cap;
    cap_src_e cap_src;
    logic [1:0] cap_edge;
    logic opt_en;
    logic pin_dir;
    logic down;
    clk_src_e src;
    logic [2:0] pre;
    logic run;
  } tmr_ctrl_s;
  localparam int CTRL_W = $bits(tmr_ctrl_s);
  localparam tmr_ctrl_s CTRL_RST = 15'h0000;
endpackage

/* src/timer_count.sv */
// One up/down counting timer with clear, write and wrap reload
`timescale 1ns/1ps
`default_nettype none
module timer_count import timer_pkg::*; #(
  parameter int WIDTH = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic tick,
  input wire logic down,
  input wire logic clear,
  input wire logic wr,
  input wire logic [WIDTH-1:0] wr_val,
  input wire logic load_en,
  input wire logic [WIDTH-1:0] load_val,
  output logic [WIDTH-1:0] cnt,
  output logic wrap
);
  logic [WIDTH-1:0] cnt_ff;
  logic at_end;

  if (WIDTH < 2 || WIDTH > 32) begin : g_bad_width
    $error("timer width must be 2 to 32");
  end

  assign at_end = down ? (cnt_ff == '0) : (cnt_ff == '1);
  assign wrap = tick && !clear && !wr && at_end;
  assign cnt = cnt_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff <= '0;
    end else if (clear) begin
      cnt_ff <= '0;
    end else if (wr) begin
      cnt_ff <= wr_val;
    end else if (wrap && load_en) begin
      cnt_ff <= load_val;
    end else if (tick) begin
      cnt_ff <= down ? cnt_ff - WIDTH'(1) : cnt_ff + WIDTH'(1);
    end
  end
endmodule
`default_nettype wire

/* src/dual_timer_capture_reload.sv */
// Dual timer unit with capture/reload register and APB slave
`timescale 1ns/1ps
`default_nettype none
module dual_timer_capture_reload import timer_pkg::*; #(
  parameter int WIDTH = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic core_count_pin,
  input wire logic aux_count_pin,
  input wire logic core_direction_input_pin,
  input wire logic aux_direction_input_pin,
  input wire logic capture_input_pin,
  input wire logic neighbour_count_input,
  input wire logic neighbour_direction_input,
  output logic toggle_output_pin,
  output logic compare_unit_b_clock,
  output logic irq
);
  tmr_ctrl_s ctrl_ff [NTMR];
  logic [WIDTH-1:0] cnt [NTMR];
  logic tick [NTMR];
  logic wrap [NTMR];
  logic tdown [NTMR];
  logic twr [NTMR];
  logic [NPIN-1:0] pins_in;
  logic [NPIN-1:0] s1_ff, s2_ff, s3_ff;
  logic [NPIN-1:0] rise, fall;
  logic [PRE_W-1:0] pre_ff;
  logic [WIDTH-1:0] capreg_ff;
  logic latch_ff, toggle_out_ff, cmp_clk_ff;
  logic [NIRQ-1:0] status_ff, mask_ff, events, nxt_status;
  logic irq_ff, pready_ff, pslverr_ff;
  logic [31:0] prdata_ff;
  logic setup, wr_en, aux_clear, cap_evt, pin_cap, nb_cap;
  logic [31:0] rdata_c;
  logic rd_err_c;

  if (WIDTH < 2 || WIDTH > 32) begin : g_bad_width
    $error("timer width must be 2 to 32");
  end

  // Pin synchronisers and edge detection
  assign pins_in = {neighbour_direction_input, neighbour_count_input, capture_input_pin,
                    aux_direction_input_pin, core_direction_input_pin,
                    aux_count_pin, core_count_pin};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_ff <= PIN_RST;
      s2_ff <= PIN_RST;
      s3_ff <= PIN_RST;
    end else begin
      s1_ff <= pins_in;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end
  assign rise = s2_ff & ~s3_ff;
  assign fall = ~s2_ff & s3_ff;

  // Free running prescaler
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_ff <= PRE_RST;
    end else begin
      pre_ff <= pre_ff + PRE_W'(1);
    end
  end

  assign setup = psel && !penable;
  assign wr_en = psel && penable && pready_ff && pwrite;

  // Per timer clocking, direction and control register
  for (genvar i = 0; i < NTMR; i++) begin : g_tmr
    logic [PRE_W-1:0] mask;
    logic pre_tick, latch_in;
    if (i == AUX_IDX) begin : g_chain
      assign latch_in = wrap[CORE_IDX];
    end else begin : g_nochain
      assign latch_in = 1'b0;
    end
    assign mask = PRE_W'((9'h002 << ctrl_ff[i].pre) - 9'h001);
    assign pre_tick = &(pre_ff | ~mask);
    always_comb begin
      tick[i] = 1'b0;
      if (ctrl_ff[i].run) begin
        case (ctrl_ff[i].src)
          SRC_PRESC: tick[i] = pre_tick;
          SRC_PIN: tick[i] = rise[PIN_CNT0+i];
          SRC_LATCH: tick[i] = latch_in;
          default: tick[i] = 1'b0;
        endcase
      end
    end
    assign tdown[i] = ctrl_ff[i].pin_dir ? s2_ff[PIN_DIR0+i] : ctrl_ff[i].down;
    assign twr[i] = wr_en && (paddr == (i == CORE_IDX ? OFF_CORE_CNT : OFF_AUX_CNT));
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        ctrl_ff[i] <= CTRL_RST;
      end else if (wr_en && paddr == (i == CORE_IDX ? OFF_CORE_CTRL : OFF_AUX_CTRL)) begin
        ctrl_ff[i] <= tmr_ctrl_s'(pwdata[CTRL_W-1:0]);
      end
    end
  end

  // Both timers, core reloads from the shared register
  timer_count #(.WIDTH(WIDTH)) u_core (
    .pclk(pclk),
    .presetn(presetn),
    .tick(tick[CORE_IDX]),
    .down(tdown[CORE_IDX]),
    .clear(1'b0),
    .wr(twr[CORE_IDX]),
    .wr_val(pwdata[WIDTH-1:0]),
    .load_en(ctrl_ff[CORE_IDX].opt_en),
    .load_val(capreg_ff),
    .cnt(cnt[CORE_IDX]),
    .wrap(wrap[CORE_IDX])
  );
  timer_count #(.WIDTH(WIDTH)) u_aux (
    .pclk(pclk),
    .presetn(presetn),
    .tick(tick[AUX_IDX]),
    .down(tdown[AUX_IDX]),
    .clear(aux_clear),
    .wr(twr[AUX_IDX]),
    .wr_val(pwdata[WIDTH-1:0]),
    .load_en(1'b0),
    .load_val(capreg_ff),
    .cnt(cnt[AUX_IDX]),
    .wrap(wrap[AUX_IDX])
  );

  // Capture trigger selection
  assign pin_cap = (ctrl_ff[AUX_IDX].cap_edge[0] && rise[PIN_CAPTURE]) ||
                   (ctrl_ff[AUX_IDX].cap_edge[1] && fall[PIN_CAPTURE]);
  assign nb_cap = (ctrl_ff[AUX_IDX].cap_src[0] && (rise[PIN_NB_CNT] || fall[PIN_NB_CNT])) ||
                  (ctrl_ff[AUX_IDX].cap_src[1] && (rise[PIN_NB_DIR] || fall[PIN_NB_DIR]));
  assign cap_evt = ctrl_ff[AUX_IDX].opt_en &&
                   (ctrl_ff[AUX_IDX].cap_src == CAP_PIN ? pin_cap : nb_cap);
  assign aux_clear = cap_evt && ctrl_ff[AUX_IDX].clr_cap;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      capreg_ff <= '0;
    end else if (cap_evt) begin
      capreg_ff <= cnt[AUX_IDX];
    end else if (wr_en && paddr == OFF_CAPTURE_RELOAD) begin
      capreg_ff <= pwdata[WIDTH-1:0];
    end
  end

  // Toggle latch, toggle pin and compare unit clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      latch_ff <= 1'b0;
      toggle_out_ff <= 1'b0;
      cmp_clk_ff <= 1'b0;
    end else begin
      latch_ff <= latch_ff ^ wrap[CORE_IDX];
      toggle_out_ff <= ctrl_ff[CORE_IDX].out_en && (latch_ff ^ wrap[CORE_IDX]);
      cmp_clk_ff <= wrap[CORE_IDX];
    end
  end

  // Sticky status, write one to clear, set wins
  assign events = {cap_evt, wrap[AUX_IDX], wrap[CORE_IDX]};
  always_comb begin
    nxt_status = status_ff;
    if (wr_en && paddr == OFF_IRQ_STATUS) begin
      nxt_status = status_ff & ~pwdata[NIRQ-1:0];
    end
    nxt_status = nxt_status | events;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_ff <= IRQ_RST;
      mask_ff <= IRQ_RST;
      irq_ff <= 1'b0;
    end else begin
      status_ff <= nxt_status;
      if (wr_en && paddr == OFF_IRQ_MASK) begin
        mask_ff <= pwdata[NIRQ-1:0];
      end
      irq_ff <= |(status_ff & mask_ff);
    end
  end

  // Read decode
  always_comb begin
    rdata_c = 32'h0000_0000;
    rd_err_c = 1'b0;
    if (paddr == OFF_CORE_CTRL) begin
      rdata_c = 32'(ctrl_ff[CORE_IDX]);
    end else if (paddr == OFF_AUX_CTRL) begin
      rdata_c = 32'(ctrl_ff[AUX_IDX]);
    end else if (paddr == OFF_CORE_CNT) begin
      rdata_c = 32'(cnt[CORE_IDX]);
    end else if (paddr == OFF_AUX_CNT) begin
      rdata_c = 32'(cnt[AUX_IDX]);
    end else if (paddr == OFF_CAPTURE_RELOAD) begin
      rdata_c = 32'(capreg_ff);
    end else if (paddr == OFF_IRQ_STATUS) begin
      rdata_c = 32'(status_ff);
    end else if (paddr == OFF_IRQ_MASK) begin
      rdata_c = 32'(mask_ff);
    end else begin
      rd_err_c = 1'b1;
    end
  end

  // APB slave, one wait free access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
    end else begin
      pready_ff <= setup;
      if (setup) begin
        pslverr_ff <= rd_err_c;
        prdata_ff <= pwrite ? 32'h0000_0000 : rdata_c;
      end
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign toggle_output_pin = toggle_out_ff;
  assign compare_unit_b_clock = cmp_clk_ff;
  assign irq = irq_ff;

  // Checks
  a_tick_spacing: assert property (@(posedge pclk) disable iff (!presetn)
    tick[CORE_IDX] |=> !tick[CORE_IDX]) else $error("core ticks closer than two clocks");
  a_pin_clock: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl_ff[CORE_IDX].run && ctrl_ff[CORE_IDX].src == SRC_PIN && rise[PIN_CNT0] |->
    tick[CORE_IDX]) else $error("count pin edge not counted");
  a_down_count: assert property (@(posedge pclk) disable iff (!presetn)
    tick[CORE_IDX] && tdown[CORE_IDX] && !wrap[CORE_IDX] && !twr[CORE_IDX] |=>
    cnt[CORE_IDX] == $past(cnt[CORE_IDX]) - WIDTH'(1)) else $error("down count wrong");
  a_latch_toggle: assert property (@(posedge pclk) disable iff (!presetn)
    wrap[CORE_IDX] |=> latch_ff != $past(latch_ff)) else $error("latch did not toggle");
  a_chain_clock: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl_ff[AUX_IDX].run && ctrl_ff[AUX_IDX].src == SRC_LATCH && wrap[CORE_IDX] |->
    tick[AUX_IDX]) else $error("aux not clocked by latch");
  a_cmp_clock: assert property (@(posedge pclk) disable iff (!presetn)
    wrap[CORE_IDX] |=> compare_unit_b_clock ##1 !compare_unit_b_clock || wrap[CORE_IDX])
    else $error("compare clock pulse missing");
  a_reload_value: assert property (@(posedge pclk) disable iff (!presetn)
    wrap[CORE_IDX] && ctrl_ff[CORE_IDX].opt_en |=> cnt[CORE_IDX] == $past(capreg_ff))
    else $error("core reload wrong");
  a_capture_copy: assert property (@(posedge pclk) disable iff (!presetn)
    cap_evt |=> capreg_ff == $past(cnt[AUX_IDX])) else $error("capture value wrong");
  a_capture_clear: assert property (@(posedge pclk) disable iff (!presetn)
    cap_evt && ctrl_ff[AUX_IDX].clr_cap |=> cnt[AUX_IDX] == '0) else $error("aux not cleared");
  a_neighbour_cap: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl_ff[AUX_IDX].opt_en && ctrl_ff[AUX_IDX].cap_src == CAP_NB_CNT && rise[PIN_NB_CNT]
    |-> cap_evt) else $error("neighbour edge did not capture");
  a_sync_latency: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(capture_input_pin) && ctrl_ff[AUX_IDX].opt_en && ctrl_ff[AUX_IDX].cap_src ==
    CAP_PIN && ctrl_ff[AUX_IDX].cap_edge[0] ##1 $stable(ctrl_ff[AUX_IDX]) ##1
    $stable(ctrl_ff[AUX_IDX]) |-> cap_evt)
    else $error("capture not two clocks after pin edge");
  a_toggle_pin: assert property (@(posedge pclk) disable iff (!presetn)
    toggle_output_pin == ($past(ctrl_ff[CORE_IDX].out_en) && latch_ff)) else $error("toggle pin wrong");
  a_capture_status: assert property (@(posedge pclk) disable iff (!presetn)
    cap_evt |=> status_ff[IRQ_CAPTURE]) else $error("capture status not set");
  a_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
    irq == $past(|(status_ff & mask_ff))) else $error("irq does not follow status");
  c_capture_clear: cover property (@(posedge pclk) disable iff (!presetn) aux_clear);
  c_core_reload: cover property (@(posedge pclk) disable iff (!presetn)
    wrap[CORE_IDX] && ctrl_ff[CORE_IDX].opt_en);
  c_chain_tick: cover property (@(posedge pclk) disable iff (!presetn)
    tick[AUX_IDX] && ctrl_ff[AUX_IDX].src == SRC_LATCH);
  c_irq: cover property (@(posedge pclk) disable iff (!presetn) irq);
  c_nb_capture: cover property (@(posedge pclk) disable iff (!presetn)
    cap_evt && ctrl_ff[AUX_IDX].cap_src != CAP_PIN);
endmodule
`default_nettype wire

/* tb/pin_model.sv */
// Model of the external event pins and neighbour timer inputs
`timescale 1ns/1ps
`default_nettype none
module pin_model import timer_pkg::*; (
  input wire logic pclk,
  output logic [NPIN-1:0] pins
);
  initial pins = PIN_RST;
  // One transition, then room for sync and edge detect
  task automatic flip(input int i);
    @(posedge pclk);
    pins[i] <= ~pins[i];
    repeat (6) @(posedge pclk);
  endtask
endmodule
`default_nettype wire

/* tb/dual_timer_capture_reload_tb.sv */
// Self-checking bench of the dual timer unit
`timescale 1ns/1ps
`default_nettype none
module dual_timer_capture_reload_tb import timer_pkg::*;;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, toggle_output_pin, compare_unit_b_clock, irq;
  logic [NPIN-1:0] pins;
  logic [31:0] rd;
  logic err;
  int mismatches = 0;
  int check_count = 0;
  int pulses = 0;
  int cap_pin[4] = '{PIN_CAPTURE, PIN_NB_CNT, PIN_NB_DIR, PIN_NB_DIR};

  always #50 pclk = ~pclk;
  always @(posedge pclk) if (compare_unit_b_clock === 1'b1) pulses++;

  pin_model pin_model_i (.pclk(pclk), .pins(pins));

  dual_timer_capture_reload #(.WIDTH(16)) dual_timer_capture_reload_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr),
    .core_count_pin(pins[PIN_CNT0+CORE_IDX]), .aux_count_pin(pins[PIN_CNT0+AUX_IDX]),
    .core_direction_input_pin(pins[PIN_DIR0+CORE_IDX]),
    .aux_direction_input_pin(pins[PIN_DIR0+AUX_IDX]),
    .capture_input_pin(pins[PIN_CAPTURE]), .neighbour_count_input(pins[PIN_NB_CNT]),
    .neighbour_direction_input(pins[PIN_NB_DIR]), .toggle_output_pin(toggle_output_pin),
    .compare_unit_b_clock(compare_unit_b_clock), .irq(irq));

  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      mismatches++;
      $display("MISMATCH t=%0t no pready", $time);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string what);
    apb(1'b0, a, 32'h0);
    chk(rd, exp, what);
  endtask

  task automatic flip2(input int i);
    pin_model_i.flip(i);
    pin_model_i.flip(i);
  endtask

  initial begin
    logic [31:0] base;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rdc(OFF_CORE_CTRL, 32'h0, "core ctrl reset");
    rdc(OFF_CAPTURE_RELOAD, 32'h0, "capture reg reset");
    rdc(OFF_IRQ_STATUS, 32'h0, "status reset");
    apb(1'b0, 8'h1c, 32'h0);
    chk({31'h0, err}, 32'h1, "unmapped error");
    $display("reset test done");
    wr(OFF_CORE_CTRL, 32'h0001);
    apb(1'b0, OFF_CORE_CNT, 32'h0);
    base = rd;
    repeat (7) @(posedge pclk);
    rdc(OFF_CORE_CNT, base + 32'h5, "prescaler rate");
    wr(OFF_CORE_CTRL, 32'h0003);
    apb(1'b0, OFF_CORE_CNT, 32'h0);
    base = rd;
    repeat (13) @(posedge pclk);
    rdc(OFF_CORE_CNT, base + 32'h4, "prescaler divide by four");
    wr(OFF_CORE_CTRL, 32'h0);
    $display("prescaler test done");
    wr(OFF_CORE_CNT, 32'h0);
    wr(OFF_CORE_CTRL, 32'h4041);
    wr(OFF_CORE_CTRL, 32'h4040);
    apb(1'b0, OFF_CORE_CNT, 32'h0);
    chk({31'h0, rd >= 32'hfffe && rd <= 32'hffff}, 32'h1, "down wrap");
    rdc(OFF_IRQ_STATUS, 32'h1, "wrap status");
    chk({31'h0, toggle_output_pin}, 32'h1, "toggle pin");
    chk(pulses, 32'h1, "compare clock");
    chk({31'h0, irq}, 32'h0, "masked irq");
    wr(OFF_IRQ_MASK, 32'h1);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h1, "irq raised");
    wr(OFF_IRQ_STATUS, 32'h1);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h0, "irq cleared");
    rdc(OFF_IRQ_STATUS, 32'h0, "status cleared");
    $display("wrap test done");
    wr(OFF_CAPTURE_RELOAD, 32'hfff0);
    wr(OFF_CORE_CNT, 32'hfffe);
    wr(OFF_CORE_CTRL, 32'h0101);
    repeat (6) @(posedge pclk);
    wr(OFF_CORE_CTRL, 32'h0100);
    apb(1'b0, OFF_CORE_CNT, 32'h0);
    chk({31'h0, rd >= 32'hfff0 && rd <= 32'hfff8}, 32'h1, "reload");
    chk({31'h0, toggle_output_pin}, 32'h0, "toggle pin off");
    $display("reload test done");
    wr(OFF_CORE_CNT, 32'h0);
    wr(OFF_CORE_CTRL, 32'h0011);
    repeat (3) flip2(PIN_CNT0 + CORE_IDX);
    rdc(OFF_CORE_CNT, 32'h3, "pin count");
    pin_model_i.flip(PIN_DIR0 + CORE_IDX);
    wr(OFF_CORE_CTRL, 32'h0091);
    flip2(PIN_CNT0 + CORE_IDX);
    rdc(OFF_CORE_CNT, 32'h2, "pin direction");
    wr(OFF_CORE_CNT, 32'h0);
    wr(OFF_AUX_CNT, 32'h0);
    wr(OFF_AUX_CTRL, 32'h0021);
    flip2(PIN_CNT0 + CORE_IDX);
    rdc(OFF_AUX_CNT, 32'h1, "chained aux");
    chk({31'h0, toggle_output_pin}, 32'h0, "toggle pin gated");
    wr(OFF_AUX_CTRL, 32'h0);
    $display("pin test done");
    for (int s = 0; s < 4; s++) begin
      wr(OFF_AUX_CNT, 32'h100 + s);
      wr(OFF_AUX_CTRL, 32'h2331 | (s << 11));
      pin_model_i.flip(cap_pin[s]);
      rdc(OFF_CAPTURE_RELOAD, 32'h100 + s, "capture");
      rdc(OFF_AUX_CNT, 32'h0, "clear on capture");
    end
    wr(OFF_AUX_CNT, 32'h77);
    wr(OFF_AUX_CTRL, 32'h2331);
    pin_model_i.flip(PIN_CAPTURE);
    rdc(OFF_CAPTURE_RELOAD, 32'h103, "falling edge ignored");
    rdc(OFF_IRQ_STATUS, 32'h5, "capture status");
    wr(OFF_AUX_CTRL, 32'h2531);
    flip2(PIN_CAPTURE);
    rdc(OFF_CAPTURE_RELOAD, 32'h77, "falling edge capture");
    rdc(OFF_AUX_CNT, 32'h0, "clear on falling capture");
    $display("capture test done");
    summarize();
  end
endmodule
`default_nettype wire
